/* File: logic/gfl_function_logic.sv */
// general I/O function logic: boolean outputs with state-machine option and input special functions
//
// Summary of operation
// [R01] each output ORs up to two AND terms
// [R02] state-machine option evaluates one term only
// [R03] result true: use term 0 until false
// [R04] result false: use term 1 until true
// [R05] term choice switches with the result change
// [R06] software assigns each special function once only
// [R07] fault-enabled pin deasserting raises a fault
// [R08] latched rail flags hold until cleared
// [R09] clear pin activation clears all latched flags
// [R10] margin enable pin margins enabled rails
// [R11] direction asserted with enable: margin low
// [R12] direction deasserted: margin high
// [R13] per-pin active-low or active-high polarity
// [R14] first three defined pins feed rail-state selector
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module gfl_function_logic
  import gfl_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  input  wire logic [NUM_IN-1:0]   general_input_pin_i,
  input  wire logic [NUM_RAIL-1:0] rail_status_i,
  input  wire logic [NUM_RAIL-1:0] rail_latch_set_i,
  output logic [NUM_OUT-1:0]       general_output_pin_o,
  output logic                     fault_event_o,
  output logic [NUM_RAIL-1:0]      rail_margin_low_o,
  output logic [NUM_RAIL-1:0]      rail_margin_high_o,
  output logic [NUM_SEL-1:0]       rail_state_select_o,
  output logic                     irq_o
);

  // ==========================================================
  // registers
  logic [31:0]         term0_mask_r [NUM_OUT];
  logic [31:0]         term1_mask_r [NUM_OUT];
  logic [15:0]         out_mode_r;
  logic [NUM_IN-1:0]   in_pol_r;
  logic [19:0]         func_sel_r;
  logic [NUM_IN-1:0]   in_def_r;
  logic [NUM_RAIL-1:0] rail_mrg_r;
  logic [IRQ_W-1:0]    irq_en_r;
  logic [IRQ_W-1:0]    irq_stat_r;
  logic [IRQ_W-1:0]    irq_stat_nxt;
  logic [NUM_RAIL-1:0] latch_r;
  logic [NUM_RAIL-1:0] latch_nxt;
  logic [NUM_OUT-1:0]  res_r;
  logic [NUM_OUT-1:0]  res_nxt;
  logic [NUM_IN-1:0]   in_s1_r;
  logic [NUM_IN-1:0]   in_s2_r;
  logic [NUM_IN-1:0]   in_s3_r;
  logic [NUM_IN-1:0]   in_stab_r;
  logic [NUM_IN-1:0]   in_act_prev_r;
  logic [NUM_SEL-1:0]  sel_nxt;
  logic [31:0]         rdata_nxt;

  // ==========================================================
  // register decode
  wire       wr_term0 = wr_i && addr_i[7:5] == ADDR_TERM0_BASE[7:5];
  wire       wr_term1 = wr_i && addr_i[7:5] == ADDR_TERM1_BASE[7:5];
  wire [2:0] term_idx = addr_i[4:2];
  wire       wr_mode  = wr_i && addr_i == ADDR_OUT_MODE;
  wire       wr_pol   = wr_i && addr_i == ADDR_IN_POL;
  wire       wr_func  = wr_i && addr_i == ADDR_FUNC_SEL;
  wire       wr_def   = wr_i && addr_i == ADDR_IN_DEF;
  wire       wr_latch = wr_i && addr_i == ADDR_LATCH;
  wire       wr_iclr  = wr_i && addr_i == ADDR_IRQ_CLR;
  wire       wr_ien   = wr_i && addr_i == ADDR_IRQ_EN;
  wire       wr_mrg   = wr_i && addr_i == ADDR_RAIL_MRG;

  // ==========================================================
  // input pins: three-stage synchroniser, polarity
  wire [NUM_IN-1:0] in_agree = ~(in_s2_r ^ in_s3_r);
  wire [NUM_IN-1:0] in_act   = ~(in_stab_r ^ in_pol_r);  // [R13]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_s1_r       <= '0;
      in_s2_r       <= '0;
      in_s3_r       <= '0;
      in_stab_r     <= '0;
      in_act_prev_r <= '0;
    end
    else
    begin
      in_s1_r       <= general_input_pin_i;
      in_s2_r       <= in_s1_r;
      in_s3_r       <= in_s2_r;
      in_stab_r     <= (in_s2_r & in_agree) | (in_stab_r & ~in_agree);
      in_act_prev_r <= in_act;
    end
  end

  // ==========================================================
  // special input functions
  wire [2:0] clr_idx  = func_sel_r[FS_CLR_IDX +: 3];
  wire [2:0] men_idx  = func_sel_r[FS_MEN_IDX +: 3];
  wire [2:0] mdir_idx = func_sel_r[FS_MDIR_IDX +: 3];
  wire [NUM_IN-1:0] fault_en = func_sel_r[FS_FAULT_LSB +: NUM_IN];
  wire [NUM_IN-1:0] deassert_edge = in_act_prev_r & ~in_act;
  wire fault_evt   = |(deassert_edge & fault_en);  // [R07]
  wire pin_clr_evt = func_sel_r[FS_CLR_VLD] && in_act[clr_idx] && !in_act_prev_r[clr_idx];  // [R09]
  wire margin_en   = func_sel_r[FS_MEN_VLD] && in_act[men_idx];  // [R10]
  wire margin_low  = margin_en && func_sel_r[FS_MDIR_VLD] && in_act[mdir_idx];  // [R11]
  wire margin_high = margin_en && !margin_low;  // [R12]

  // latched flags: a new set wins over a clear in the same cycle
  wire [NUM_RAIL-1:0] latch_clr = {NUM_RAIL{pin_clr_evt}} | ({NUM_RAIL{wr_latch}} & wdata_i[NUM_RAIL-1:0]);
  assign latch_nxt = (latch_r & ~latch_clr) | rail_latch_set_i;  // [R08] [R09]

  // first three defined input pins, in pin order, feed the selector
  always_comb
  begin
    logic [1:0] cnt;
    cnt     = 2'd0;
    sel_nxt = '0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (in_def_r[i] && cnt < 2'd3)
      begin
        sel_nxt[cnt] = in_act[i];  // [R14]
        cnt          = cnt + 2'd1;
      end
    end
  end

  // ==========================================================
  // boolean output logic
  logic [NUM_OUT-1:0] t0;
  logic [NUM_OUT-1:0] t1;
  wire  [NUM_OUT-1:0] sm_en  = out_mode_r[OM_SM_LSB +: NUM_OUT];
  wire  [NUM_OUT-1:0] lat_sel = out_mode_r[OM_LATSEL_LSB +: NUM_OUT];

  generate
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : g_out
      wire [NUM_RAIL-1:0] rail_v = lat_sel[g] ? latch_r : rail_status_i;
      wire [SRC_W-1:0]    src    = {rail_v, in_act, res_r};
      // an empty term never fires
      assign t0[g] = |term0_mask_r[g] && (src & term0_mask_r[g]) == term0_mask_r[g];  // [R01]
      assign t1[g] = |term1_mask_r[g] && (src & term1_mask_r[g]) == term1_mask_r[g];  // [R01]
      // the active term follows the current result, so it flips with it
      assign res_nxt[g] = sm_en[g] ? (res_r[g] ? t0[g] : t1[g]) : (t0[g] | t1[g]);  // [R02] [R03] [R04] [R05]
    end
  endgenerate

  // ==========================================================
  // interrupts
  wire [IRQ_W-1:0] irq_evt = {|(res_nxt ^ res_r), pin_clr_evt, fault_evt};
  assign irq_stat_nxt = (irq_stat_r & ~({IRQ_W{wr_iclr}} & wdata_i[IRQ_W-1:0])) | irq_evt;
  assign irq_o        = |(irq_stat_r & irq_en_r);

  // ==========================================================
  // read mux
  wire [31:0] status_w = {14'h0000, margin_low, margin_en, in_act, res_r};
  assign rdata_nxt =
    (addr_i[7:5] == ADDR_TERM0_BASE[7:5]) ? term0_mask_r[term_idx] :
    (addr_i[7:5] == ADDR_TERM1_BASE[7:5]) ? term1_mask_r[term_idx] :
    (addr_i == ADDR_OUT_MODE)  ? {16'h0000, out_mode_r} :
    (addr_i == ADDR_IN_POL)    ? {24'h000000, in_pol_r} :
    (addr_i == ADDR_FUNC_SEL)  ? {12'h000, func_sel_r} :
    (addr_i == ADDR_IN_DEF)    ? {24'h000000, in_def_r} :
    (addr_i == ADDR_STATUS)    ? status_w :
    (addr_i == ADDR_LATCH)     ? {16'h0000, latch_r} :
    (addr_i == ADDR_IRQ_STAT)  ? {29'h00000000, irq_stat_r} :
    (addr_i == ADDR_IRQ_EN)    ? {29'h00000000, irq_en_r} :
    (addr_i == ADDR_RAIL_MRG)  ? {16'h0000, rail_mrg_r} : 32'h0000_0000;

  // ==========================================================
  // register file and outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        term0_mask_r[i] <= RST_TERM;
        term1_mask_r[i] <= RST_TERM;
      end
      out_mode_r <= RST_OUT_MODE;
      in_pol_r   <= RST_IN_POL;
      func_sel_r <= RST_FUNC_SEL;
      in_def_r   <= RST_IN_DEF;
      rail_mrg_r <= RST_RAIL_MRG;
      irq_en_r   <= RST_IRQ_EN;
    end
    else
    begin
      if (wr_term0) term0_mask_r[term_idx] <= wdata_i;
      if (wr_term1) term1_mask_r[term_idx] <= wdata_i;
      if (wr_mode)  out_mode_r <= wdata_i[15:0];
      if (wr_pol)   in_pol_r   <= wdata_i[NUM_IN-1:0];
      if (wr_func)  func_sel_r <= wdata_i[19:0];
      if (wr_def)   in_def_r   <= wdata_i[NUM_IN-1:0];
      if (wr_mrg)   rail_mrg_r <= wdata_i[NUM_RAIL-1:0];
      if (wr_ien)   irq_en_r   <= wdata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_r             <= '0;
      res_r               <= '0;
      irq_stat_r          <= '0;
      rdata_o             <= '0;
      fault_event_o       <= 1'b0;
      rail_margin_low_o   <= '0;
      rail_margin_high_o  <= '0;
      rail_state_select_o <= '0;
    end
    else
    begin
      latch_r             <= latch_nxt;
      res_r               <= res_nxt;
      irq_stat_r          <= irq_stat_nxt;
      rdata_o             <= rd_i ? rdata_nxt : 32'h0000_0000;
      fault_event_o       <= fault_evt;
      rail_margin_low_o   <= rail_mrg_r & {NUM_RAIL{margin_low}};
      rail_margin_high_o  <= rail_mrg_r & {NUM_RAIL{margin_high}};
      rail_state_select_o <= sel_nxt;
    end
  end

  assign general_output_pin_o = res_r;

  // ==========================================================
  // assertions
  property p_or_terms;
    @(posedge clk_i) disable iff (rst_i)
      (|(~sm_en)) |=> ((res_r ^ $past(t0 | t1)) & $past(~sm_en)) == '0;
  endproperty
  a_or_terms: assert property (p_or_terms) else $error("output not OR of terms");  // [R01]

  property p_sm_true;
    @(posedge clk_i) disable iff (rst_i)
      (|(sm_en & res_r)) |=> ((res_r ^ $past(t0)) & $past(sm_en & res_r)) == '0;
  endproperty
  a_sm_true: assert property (p_sm_true) else $error("true state not using term 0");  // [R03]

  property p_sm_false;
    @(posedge clk_i) disable iff (rst_i)
      (|(sm_en & ~res_r)) |=> ((res_r ^ $past(t1)) & $past(sm_en & ~res_r)) == '0;
  endproperty
  a_sm_false: assert property (p_sm_false) else $error("false state not using term 1");  // [R04]

  property p_sm_one_term;
    @(posedge clk_i) disable iff (rst_i)
      (|(sm_en & ~res_r & t0 & ~t1)) |=> (res_r & $past(sm_en & ~res_r & t0 & ~t1)) == '0;
  endproperty
  a_sm_one_term: assert property (p_sm_one_term) else $error("term 0 used in false state");  // [R02] [R05]

  property p_fault;
    @(posedge clk_i) disable iff (rst_i) (|(in_act_prev_r & ~in_act & fault_en)) |=> fault_event_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault edge missed");  // [R07]

  property p_no_fault;
    @(posedge clk_i) disable iff (rst_i) !(|(in_act_prev_r & ~in_act & fault_en)) |=> !fault_event_o;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("spurious fault event");  // [R07]

  property p_latch_hold;
    @(posedge clk_i) disable iff (rst_i) !pin_clr_evt && !wr_latch |=> ($past(latch_r) & ~latch_r) == '0;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");  // [R08]

  property p_pin_clear;
    @(posedge clk_i) disable iff (rst_i) pin_clr_evt && rail_latch_set_i == '0 |=> latch_r == '0;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("clear pin did not clear");  // [R09]

  property p_margin_low;
    @(posedge clk_i) disable iff (rst_i) margin_low |=> rail_margin_low_o == $past(rail_mrg_r);
  endproperty
  a_margin_low: assert property (p_margin_low) else $error("margin low not applied");  // [R10] [R11]

  property p_margin_high;
    @(posedge clk_i) disable iff (rst_i)
      margin_en && !in_act[mdir_idx] |=> rail_margin_high_o == $past(rail_mrg_r) && rail_margin_low_o == '0;
  endproperty
  a_margin_high: assert property (p_margin_high) else $error("margin high not applied");  // [R12]

  property p_margin_off;
    @(posedge clk_i) disable iff (rst_i) !margin_en |=> rail_margin_low_o == '0 && rail_margin_high_o == '0;
  endproperty
  a_margin_off: assert property (p_margin_off) else $error("margin applied without enable");  // [R10]

  // a settled synchroniser level must reach the active flag through the polarity setting
  property p_polarity;
    @(posedge clk_i) disable iff (rst_i)
      in_s2_r[0] == in_s3_r[0] |=> in_act[0] == ($past(in_s3_r[0]) ~^ in_pol_r[0]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin polarity misread");  // [R13]

  property p_selector;
    @(posedge clk_i) disable iff (rst_i) in_def_r[2:0] == 3'h7 |=> rail_state_select_o == $past(in_act[2:0]);
  endproperty
  a_selector: assert property (p_selector) else $error("selector not from first pins");  // [R14]

endmodule

/* File: logic/gfl_pkg.sv */
// package: register map, field layout and sizes of the general I/O function logic
package gfl_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_IN   = 8;
  localparam int NUM_OUT  = 8;
  localparam int NUM_RAIL = 16;
  localparam int SRC_W    = NUM_RAIL + NUM_IN + NUM_OUT;
  localparam int NUM_SEL  = 3;
  localparam int IRQ_W    = 3;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_TERM0_BASE = 8'h00;
  localparam logic [7:0] ADDR_TERM1_BASE = 8'h20;
  localparam logic [7:0] ADDR_OUT_MODE   = 8'h40;
  localparam logic [7:0] ADDR_IN_POL     = 8'h44;
  localparam logic [7:0] ADDR_FUNC_SEL   = 8'h48;
  localparam logic [7:0] ADDR_IN_DEF     = 8'h4c;
  localparam logic [7:0] ADDR_STATUS     = 8'h50;
  localparam logic [7:0] ADDR_LATCH      = 8'h54;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h58;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h5c;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h60;
  localparam logic [7:0] ADDR_RAIL_MRG   = 8'h64;

  // ==========================================================
  // field positions
  localparam int OM_SM_LSB     = 0;
  localparam int OM_LATSEL_LSB = 8;
  localparam int FS_FAULT_LSB  = 0;
  localparam int FS_CLR_IDX    = 8;
  localparam int FS_CLR_VLD    = 11;
  localparam int FS_MEN_IDX    = 12;
  localparam int FS_MEN_VLD    = 15;
  localparam int FS_MDIR_IDX   = 16;
  localparam int FS_MDIR_VLD   = 19;
  localparam int ST_IN_LSB     = 8;
  localparam int ST_MEN        = 16;
  localparam int ST_MLOW       = 17;
  localparam int IRQ_FAULT     = 0;
  localparam int IRQ_PINCLR    = 1;
  localparam int IRQ_OUTCHG    = 2;

  // ==========================================================
  // reset values
  localparam logic [31:0] RST_TERM     = 32'h0000_0000;
  localparam logic [15:0] RST_OUT_MODE = 16'h0000;
  localparam logic [7:0]  RST_IN_POL   = 8'hff;
  localparam logic [19:0] RST_FUNC_SEL = 20'h00000;
  localparam logic [7:0]  RST_IN_DEF   = 8'h00;
  localparam logic [15:0] RST_RAIL_MRG = 16'h0000;
  localparam logic [2:0]  RST_IRQ_EN   = 3'h0;

endpackage

/* File: testbench/gfl_sys_model.sv */
// system side of the function logic: signals driving the input pins, loads on the outputs
`timescale 1ns/1ps
module gfl_sys_model
  import gfl_pkg::*;
(
  input  wire logic [NUM_IN-1:0]   pin_lvl_i,
  input  wire logic [NUM_RAIL-1:0] rail_lvl_i,
  input  wire logic [NUM_RAIL-1:0] latch_req_i,
  input  wire logic [NUM_OUT-1:0]  load_i,
  output logic      [NUM_IN-1:0]   pin_o,
  output logic      [NUM_RAIL-1:0] rail_o,
  output logic      [NUM_RAIL-1:0] latch_set_o
);
  // ==========================================================
  // pins carry raw levels, the block applies polarity
  assign pin_o       = pin_lvl_i;
  assign rail_o      = rail_lvl_i;
  assign latch_set_o = latch_req_i;
endmodule

/* File: testbench/testbench.sv */
// self-checking testbench of the general I/O function logic
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench
  import gfl_pkg::*;
;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic [7:0]          addr_i = 8'h00;
  logic [31:0]         wdata_i = 32'h0;
  logic                wr_i = 1'b0;
  logic                rd_i = 1'b0;
  logic [31:0]         rdata_o;
  logic [NUM_IN-1:0]   pin_lvl = '0;
  logic [NUM_RAIL-1:0] rail_lvl = '0;
  logic [NUM_RAIL-1:0] latch_req = '0;
  logic [NUM_IN-1:0]   pins;
  logic [NUM_RAIL-1:0] rails;
  logic [NUM_RAIL-1:0] lset;
  logic [NUM_OUT-1:0]  outs;
  logic                fault_o;
  logic [NUM_RAIL-1:0] mlow;
  logic [NUM_RAIL-1:0] mhigh;
  logic [NUM_SEL-1:0]  sel;
  logic                irq_o;
  logic [31:0]         d;
  int                  num_errors = 0;
  int                  checks = 0;
  always #20 clk_i = ~clk_i;
  // ==========================================================
  // instances
  gfl_sys_model u_gfl_sys_model (.pin_lvl_i(pin_lvl), .rail_lvl_i(rail_lvl), .latch_req_i(latch_req),
    .load_i(outs), .pin_o(pins), .rail_o(rails), .latch_set_o(lset));
  gfl_function_logic u_gfl_function_logic (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .general_input_pin_i(pins), .rail_status_i(rails),
    .rail_latch_set_i(lset), .general_output_pin_o(outs), .fault_event_o(fault_o),
    .rail_margin_low_o(mlow), .rail_margin_high_o(mhigh), .rail_state_select_o(sel), .irq_o(irq_o));
  // ==========================================================
  // bus and helper tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    rd(ADDR_OUT_MODE); `CHK(d, 32'h0)
    rd(ADDR_IN_POL);   `CHK(d, 32'h0000_00ff)
    rd(ADDR_FUNC_SEL); `CHK(d, 32'h0)
    rd(ADDR_IN_DEF);   `CHK(d, 32'h0)
    rd(8'h70);         `CHK(d, 32'h0)
  endtask
  task automatic t_or_terms();
    wr(ADDR_TERM0_BASE, 32'h0001_0000);
    wr(ADDR_TERM1_BASE, 32'h0000_0200);
    @(posedge clk_i) rail_lvl <= 16'h0001;
    settle(); `CHK(outs[0], 1'b1)
    @(posedge clk_i) begin rail_lvl <= 16'h0000; pin_lvl <= 8'h02; end
    settle(); `CHK(outs[0], 1'b1)
    @(posedge clk_i) pin_lvl <= 8'h00;
    settle(); `CHK(outs[0], 1'b0)
  endtask
  task automatic t_state_machine();
    wr(8'h04, 32'h0002_0000);
    wr(8'h24, 32'h0004_0000);
    wr(ADDR_OUT_MODE, 32'h0000_0002);
    @(posedge clk_i) rail_lvl <= 16'h0002;
    settle(); `CHK(outs[1], 1'b0)
    @(posedge clk_i) rail_lvl <= 16'h0006;
    settle(); `CHK(outs[1], 1'b1)
    @(posedge clk_i) rail_lvl <= 16'h0002;
    settle(); `CHK(outs[1], 1'b1)
    @(posedge clk_i) rail_lvl <= 16'h0000;
    settle(); `CHK(outs[1], 1'b0)
    @(posedge clk_i) rail_lvl <= 16'h0002;
    settle(); `CHK(outs[1], 1'b0)
  endtask
  task automatic t_fault_polarity();
    int n;
    n = 0;
    wr(ADDR_IN_POL, 32'h0000_00fb);
    settle();
    rd(ADDR_STATUS); `CHK(d[15:8], 8'h04)
    wr(ADDR_IN_POL, 32'h0000_00ff);
    wr(ADDR_FUNC_SEL, 32'h0000_0001);
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    @(posedge clk_i) pin_lvl <= 8'h01;
    settle(); `CHK(irq_o, 1'b0)
    @(posedge clk_i) pin_lvl <= 8'h00;
    repeat (8)
    begin
      @(posedge clk_i);
      #1 if (fault_o === 1'b1) n++;
    end
    `CHK(n, 1)
    `CHK(irq_o, 1'b1)
    rd(ADDR_IRQ_STAT); `CHK(d[0], 1'b1)
    wr(ADDR_IRQ_CLR, 32'h0000_0001);
    settle(); `CHK(irq_o, 1'b0)
  endtask
  task automatic t_latch_clear();
    @(posedge clk_i) latch_req <= 16'h0008;
    @(posedge clk_i) latch_req <= 16'h0000;
    settle();
    rd(ADDR_LATCH); `CHK(d[15:0], 16'h0008)
    wr(ADDR_FUNC_SEL, 32'h0000_0c00);
    settle();
    rd(ADDR_LATCH); `CHK(d[15:0], 16'h0008)
    @(posedge clk_i) pin_lvl <= 8'h10;
    settle();
    rd(ADDR_LATCH); `CHK(d[15:0], 16'h0000)
    rd(ADDR_IRQ_STAT); `CHK(d[1], 1'b1)
    @(posedge clk_i) pin_lvl <= 8'h00;
  endtask
  task automatic t_margin();
    wr(ADDR_RAIL_MRG, 32'h0000_0005);
    wr(ADDR_FUNC_SEL, 32'h000e_d000);
    @(posedge clk_i) pin_lvl <= 8'h20;
    settle(); `CHK({mlow, mhigh}, 32'h0000_0005)
    @(posedge clk_i) pin_lvl <= 8'h60;
    settle(); `CHK({mlow, mhigh}, 32'h0005_0000)
    @(posedge clk_i) pin_lvl <= 8'h40;
    settle(); `CHK({mlow, mhigh}, 32'h0000_0000)
  endtask
  task automatic t_selector();
    wr(ADDR_IN_DEF, 32'h0000_00b2);
    @(posedge clk_i) pin_lvl <= 8'h22;
    settle(); `CHK(sel, 3'b101)
    @(posedge clk_i) pin_lvl <= 8'h90;
    settle(); `CHK(sel, 3'b010)
    wr(ADDR_IN_DEF, 32'h0000_0007);
    @(posedge clk_i) pin_lvl <= 8'h05;
    settle(); `CHK(sel, 3'b101)
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_or_terms();
    t_state_machine();
    t_fault_polarity();
    t_latch_clear();
    t_margin();
    t_selector();
    end_sim();
  end
  initial
  begin
    #(40 * 5000);
    num_errors++;
    end_sim();
  end
endmodule
